// [common/ecl_pkg.sv]
package ecl_pkg;

	// ****************************************************************
	// Opcodes seen on the serial link
	// ****************************************************************
	localparam logic [7:0] ECL_OP_UNIT_QUERY = 8'h19;
	localparam logic [7:0] ECL_OP_CLEAR_LOG = 8'h1B;
	localparam logic [7:0] ECL_OP_CRC_START = 8'h5B;
	localparam logic [7:0] ECL_OP_CRC_PAUSE = 8'h75;
	localparam logic [7:0] ECL_OP_CRC_CONTINUE = 8'h7A;

	// ****************************************************************
	// Line modes and frame field lengths
	// ****************************************************************
	localparam logic [1:0] ECL_LINES_SINGLE = 2'h0;
	localparam logic [1:0] ECL_LINES_DUAL = 2'h1;
	localparam logic [1:0] ECL_LINES_QUAD = 2'h2;
	localparam logic [4:0] ECL_STEP_SINGLE = 5'h01;
	localparam logic [4:0] ECL_STEP_DUAL = 5'h02;
	localparam logic [4:0] ECL_STEP_QUAD = 5'h04;
	localparam logic [4:0] ECL_OPCODE_BITS = 5'h08;
	localparam logic [4:0] ECL_ADDR_BITS = 5'h18;
	localparam logic [4:0] ECL_STATUS_BITS = 5'h08;
	localparam int ECL_ADDR_W = 24;
	localparam int ECL_UNIT_LSB = 3;
	localparam int ECL_UNIT_W = ECL_ADDR_W - ECL_UNIT_LSB;

	// ****************************************************************
	// Register layouts and reset values
	// ****************************************************************
	localparam int ECL_STATUS_TRIPLE_BIT = 4;
	localparam int ECL_UNIT_TRIPLE_BIT = 3;
	localparam int ECL_COUNT_W = 16;
	localparam int ECL_TRAP_W = 32;
	localparam logic [15:0] ECL_COUNT_RESET = 16'h0000;
	localparam logic [15:0] ECL_COUNT_MAX = 16'hFFFF;
	localparam logic [31:0] ECL_TRAP_RESET = 32'h0000_0000;
	localparam logic [7:0] ECL_BYTE_ZERO = 8'h00;
	localparam int ECL_WIP_BIT = 0;

	// ****************************************************************
	// Checksum
	// ****************************************************************
	localparam logic [31:0] ECL_CRC_POLY = 32'h1EDC_6F41;
	localparam logic [31:0] ECL_CRC_INIT = 32'h0000_0000;

	// ****************************************************************
	// State types
	// ****************************************************************
	typedef enum logic [2:0] {
		ECL_LINK_OPCODE,
		ECL_LINK_ADDR,
		ECL_LINK_DUMMY,
		ECL_LINK_DATA,
		ECL_LINK_DONE
	} ecl_link_state_e;

	typedef enum logic [1:0] {
		ECL_CRC_IDLE,
		ECL_CRC_RUN,
		ECL_CRC_PAUSED
	} ecl_crc_state_e;

endpackage : ecl_pkg

// [verilog/ecl_sync.sv]
`timescale 1ns/10ps
module ecl_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_en,
	// Data
	input wire logic [WIDTH-1:0] i_d,
	output logic [WIDTH-1:0] o_q
);

	logic [WIDTH-1:0] meta_reg;

	// The first stage feeds only the second stage.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta_reg <= '0;
			o_q <= '0;
		end else if (i_en) begin
			meta_reg <= i_d;
			o_q <= meta_reg;
		end
	end

endmodule : ecl_sync

// [verilog/ecl_crc32c.sv]
`timescale 1ns/10ps
module ecl_crc32c
	import ecl_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_ce,
	// Commands
	input wire logic i_start,
	input wire logic i_pause,
	input wire logic i_continue,
	// Array words
	input wire logic i_word_valid,
	input wire logic [31:0] i_word,
	input wire logic i_word_last,
	output logic o_word_ready,
	// Results
	output logic [31:0] o_crc,
	output logic o_busy,
	output logic o_paused
);

	ecl_crc_state_e state_reg;
	logic [31:0] crc_next;

	function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic [31:0] w);
		logic [31:0] c;
		logic [31:0] d;
		c = crc;
		d = {w[7:0], w[15:8], w[23:16], w[31:24]};
		for (int i = 31; i >= 0; i--) begin
			c = c[31] ^ d[i] ? ({c[30:0], 1'b0} ^ ECL_CRC_POLY) : {c[30:0], 1'b0};
		end
		return c;
	endfunction : crc_step

	assign crc_next = crc_step(o_crc, i_word);
	assign o_word_ready = (state_reg == ECL_CRC_RUN);

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_reg <= ECL_CRC_IDLE;
		end else if (i_ce) begin
			case (state_reg)
				ECL_CRC_IDLE: begin
					if (i_start) begin
						state_reg <= ECL_CRC_RUN;
					end
				end
				ECL_CRC_RUN: begin
					if (i_word_valid && i_word_last) begin
						state_reg <= ECL_CRC_IDLE;
					end else if (i_pause) begin
						state_reg <= ECL_CRC_PAUSED;
					end
				end
				ECL_CRC_PAUSED: begin
					if (i_continue) begin
						state_reg <= ECL_CRC_RUN;
					end
				end
				default: begin
					state_reg <= ECL_CRC_IDLE;
				end
			endcase
		end
	end

	// Only array words arrive here, so special-sector and register data cannot enter.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_crc <= ECL_CRC_INIT;
		end else if (i_ce) begin
			if (state_reg == ECL_CRC_IDLE && i_start) begin
				o_crc <= ECL_CRC_INIT;
			end else if (state_reg == ECL_CRC_RUN && i_word_valid) begin
				o_crc <= crc_next;
			end
		end
	end

	assign o_busy = (state_reg == ECL_CRC_RUN);
	assign o_paused = (state_reg == ECL_CRC_PAUSED);

endmodule : ecl_crc32c

// [verilog/ecl_error_log.sv]
// Function
// - Triple-error flag, status bit four, sticky.
// - Sixteen-bit counter counts triple errors from zero.
// - Counter saturates at maximum, never wraps.
// - Deep sleep clears the counter to zero.
// - Counter read-only, bits 15..0, default zero.
// - Trap holds first failing unit address.
// - Later errors leave trap, only count.
// - Trap read-only, zero after reset or sleep.
// - Query opcode 19h, 24-bit address, SDR.
// - Query ignores the three lowest address bits.
// - Query answers one status byte after dummies.
// - Dummy cycle count follows memory latency code.
// - Status byte bit three flags unit error.
// - Clear-log 1Bh clears flag, trap, counter.
// - Clear-log needs no write enable latch.
// - Checksum covers main array data only.
// - Opcode 5Bh starts a checksum computation.
// - Opcode 75h pauses the running checksum.
// - Opcode 7Ah continues a paused checksum.
// - All error records refer to eight-byte units.
// - Two-bit errors set no flag or counter.
// - In-progress bit high while checksum runs.
// - Checksum is CRC-32C, polynomial 1EDC6F41.
`timescale 1ns/10ps
module ecl_error_log
	import ecl_pkg::*;
(
	// System clock, reset and enable
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_ce,
	// Serial link
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic [3:0] i_io,
	output logic [3:0] o_io,
	output logic [3:0] o_io_oe_n,
	// Link configuration
	input wire logic [1:0] i_line_mode,
	input wire logic [3:0] i_latency_code,
	// Array read path events
	input wire logic i_triple_detect,
	input wire logic [23:0] i_detect_addr,
	input wire logic i_reset_event,
	input wire logic i_deep_sleep,
	// Unit query towards the array
	output logic o_unit_query,
	output logic [20:0] o_unit_query_index,
	input wire logic i_unit_answer,
	input wire logic i_unit_triple,
	// Checksum data path
	input wire logic i_crc_word_valid,
	input wire logic [31:0] i_crc_word,
	input wire logic i_crc_word_last,
	output logic o_crc_word_ready,
	// Register values for the generic register read
	output logic [7:0] o_error_status,
	output logic [15:0] o_triple_error_count,
	output logic [31:0] o_first_error_address,
	output logic [7:0] o_status_one,
	output logic [31:0] o_crc_value,
	output logic o_crc_paused
);

	// ****************************************************************
	// Link domain
	// ****************************************************************
	logic link_rst_n;
	logic [5:0] cfg_sync;
	logic [1:0] mode_lnk;
	logic [3:0] latency_lnk;
	logic [4:0] step;
	ecl_link_state_e link_state_reg;
	logic [4:0] bit_cnt_reg;
	logic [4:0] bit_cnt_next;
	logic [3:0] dummy_cnt_reg;
	logic [23:0] shift_reg;
	logic [23:0] shift_next;
	logic query_tgl_reg;
	logic clear_tgl_reg;
	logic start_tgl_reg;
	logic pause_tgl_reg;
	logic cont_tgl_reg;
	logic [20:0] query_index_reg;
	logic ack_lnk;
	logic [7:0] out_shift_reg;
	logic out_started_reg;
	logic [7:0] answer_byte;
	logic answer_bit_reg;

	// A raised select ends the frame; the event toggles survive it.
	assign link_rst_n = i_arst_n & ~i_cs_n;

	// Configuration is quasi-static; it is resynchronised once per link edge.
	ecl_sync #(
		.WIDTH(6)
	) u_cfg_sync (
		.i_clk(i_sck),
		.i_arst_n(i_arst_n),
		.i_en(1'b1),
		.i_d({i_line_mode, i_latency_code}),
		.o_q(cfg_sync)
	);
	assign mode_lnk = cfg_sync[5:4];
	assign latency_lnk = cfg_sync[3:0];

	always_comb begin
		case (mode_lnk)
			ECL_LINES_DUAL: begin
				step = ECL_STEP_DUAL;
				shift_next = {shift_reg[21:0], i_io[1:0]};
			end
			ECL_LINES_QUAD: begin
				step = ECL_STEP_QUAD;
				shift_next = {shift_reg[19:0], i_io[3:0]};
			end
			default: begin
				step = ECL_STEP_SINGLE;
				shift_next = {shift_reg[22:0], i_io[0]};
			end
		endcase
	end
	assign bit_cnt_next = bit_cnt_reg + step;

	always_ff @(posedge i_sck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			link_state_reg <= ECL_LINK_OPCODE;
			bit_cnt_reg <= '0;
			dummy_cnt_reg <= '0;
			shift_reg <= '0;
		end else begin
			shift_reg <= shift_next;
			bit_cnt_reg <= bit_cnt_next;
			case (link_state_reg)
				ECL_LINK_OPCODE: begin
					if (bit_cnt_next == ECL_OPCODE_BITS) begin
						bit_cnt_reg <= '0;
						if (shift_next[7:0] == ECL_OP_UNIT_QUERY) begin
							link_state_reg <= ECL_LINK_ADDR;
						end else begin
							link_state_reg <= ECL_LINK_DONE;
						end
					end
				end
				ECL_LINK_ADDR: begin
					if (bit_cnt_next == ECL_ADDR_BITS) begin
						bit_cnt_reg <= '0;
						dummy_cnt_reg <= '0;
						if (latency_lnk == 4'h0) begin
							link_state_reg <= ECL_LINK_DATA;
						end else begin
							link_state_reg <= ECL_LINK_DUMMY;
						end
					end
				end
				ECL_LINK_DUMMY: begin
					bit_cnt_reg <= '0;
					dummy_cnt_reg <= dummy_cnt_reg + 4'h1;
					if (dummy_cnt_reg + 4'h1 == latency_lnk) begin
						link_state_reg <= ECL_LINK_DATA;
					end
				end
				ECL_LINK_DATA: begin
					if (bit_cnt_next == ECL_STATUS_BITS) begin
						link_state_reg <= ECL_LINK_DONE;
					end
				end
				ECL_LINK_DONE: begin
					bit_cnt_reg <= '0;
				end
				default: begin
					link_state_reg <= ECL_LINK_DONE;
				end
			endcase
		end
	end

	// Each toggle flips on the edge that completes its opcode or address.
	always_ff @(posedge i_sck or negedge i_arst_n) begin
		if (!i_arst_n) begin
			query_tgl_reg <= 1'b0;
			clear_tgl_reg <= 1'b0;
			start_tgl_reg <= 1'b0;
			pause_tgl_reg <= 1'b0;
			cont_tgl_reg <= 1'b0;
			query_index_reg <= '0;
		end else if (!i_cs_n) begin
			if (link_state_reg == ECL_LINK_OPCODE && bit_cnt_next == ECL_OPCODE_BITS) begin
				case (shift_next[7:0])
					ECL_OP_CLEAR_LOG: clear_tgl_reg <= ~clear_tgl_reg;
					ECL_OP_CRC_START: start_tgl_reg <= ~start_tgl_reg;
					ECL_OP_CRC_PAUSE: pause_tgl_reg <= ~pause_tgl_reg;
					ECL_OP_CRC_CONTINUE: cont_tgl_reg <= ~cont_tgl_reg;
					default: begin
					end
				endcase
			end
			if (link_state_reg == ECL_LINK_ADDR && bit_cnt_next == ECL_ADDR_BITS) begin
				query_index_reg <= shift_next[ECL_ADDR_W-1:ECL_UNIT_LSB];
				query_tgl_reg <= ~query_tgl_reg;
			end
		end
	end

	// A late answer reads as a clean unit; the latency code must cover the crossing.
	assign answer_byte = (ack_lnk == query_tgl_reg) ?
		(ECL_BYTE_ZERO | (8'(answer_bit_reg) << ECL_UNIT_TRIPLE_BIT)) : ECL_BYTE_ZERO;

	always_ff @(negedge i_sck or negedge link_rst_n) begin
		if (!link_rst_n) begin
			out_shift_reg <= '0;
			out_started_reg <= 1'b0;
		end else if (link_state_reg == ECL_LINK_DATA) begin
			if (!out_started_reg) begin
				out_shift_reg <= answer_byte;
				out_started_reg <= 1'b1;
			end else begin
				out_shift_reg <= out_shift_reg << step;
			end
		end
	end

	always_comb begin
		o_io = 4'h0;
		o_io_oe_n = 4'hF;
		if (link_state_reg == ECL_LINK_DATA && out_started_reg) begin
			case (mode_lnk)
				ECL_LINES_DUAL: begin
					o_io[1:0] = out_shift_reg[7:6];
					o_io_oe_n[1:0] = 2'h0;
				end
				ECL_LINES_QUAD: begin
					o_io = out_shift_reg[7:4];
					o_io_oe_n = 4'h0;
				end
				default: begin
					o_io[1] = out_shift_reg[7];
					o_io_oe_n[1] = 1'b0;
				end
			endcase
		end
	end

	// ****************************************************************
	// System domain crossings
	// ****************************************************************
	logic [4:0] evt_sync;
	logic [4:0] evt_prev_reg;
	logic [4:0] evt_pulse;
	logic query_pulse;
	logic clear_pulse;
	logic start_pulse;
	logic pause_pulse;
	logic cont_pulse;
	logic ack_tgl_reg;
	logic wait_answer_reg;

	ecl_sync #(
		.WIDTH(5)
	) u_evt_sync (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_en(i_ce),
		.i_d({query_tgl_reg, clear_tgl_reg, start_tgl_reg, pause_tgl_reg, cont_tgl_reg}),
		.o_q(evt_sync)
	);

	ecl_sync #(
		.WIDTH(1)
	) u_ack_sync (
		.i_clk(i_sck),
		.i_arst_n(i_arst_n),
		.i_en(1'b1),
		.i_d(ack_tgl_reg),
		.o_q(ack_lnk)
	);

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			evt_prev_reg <= '0;
		end else if (i_ce) begin
			evt_prev_reg <= evt_sync;
		end
	end
	assign evt_pulse = (evt_sync ^ evt_prev_reg) & {5{i_ce}};
	assign query_pulse = evt_pulse[4];
	assign clear_pulse = evt_pulse[3];
	assign start_pulse = evt_pulse[2];
	assign pause_pulse = evt_pulse[1];
	assign cont_pulse = evt_pulse[0];

	// ****************************************************************
	// Unit query to the array
	// ****************************************************************
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_unit_query <= 1'b0;
			o_unit_query_index <= '0;
			wait_answer_reg <= 1'b0;
			answer_bit_reg <= 1'b0;
			ack_tgl_reg <= 1'b0;
		end else if (i_ce) begin
			o_unit_query <= query_pulse;
			if (query_pulse) begin
				o_unit_query_index <= query_index_reg;
				wait_answer_reg <= 1'b1;
			end else if (wait_answer_reg && i_unit_answer) begin
				answer_bit_reg <= i_unit_triple;
				ack_tgl_reg <= ~ack_tgl_reg;
				wait_answer_reg <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Error log
	// ****************************************************************
	logic flag_reg;
	logic trap_valid_reg;
	logic [31:0] trap_addr;
	logic wipe;

	assign wipe = i_reset_event | i_deep_sleep;
	assign trap_addr = {8'h00, i_detect_addr[ECL_ADDR_W-1:ECL_UNIT_LSB], 3'b000};

	// Only triple detections reach this log; corrected two-bit errors never do.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			flag_reg <= 1'b0;
		end else if (i_ce) begin
			if (wipe) begin
				flag_reg <= 1'b0;
			end else if (i_triple_detect) begin
				flag_reg <= 1'b1;
			end else if (clear_pulse) begin
				flag_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_triple_error_count <= ECL_COUNT_RESET;
		end else if (i_ce) begin
			if (wipe) begin
				o_triple_error_count <= ECL_COUNT_RESET;
			end else if (clear_pulse) begin
				o_triple_error_count <= i_triple_detect ? 16'h0001 : ECL_COUNT_RESET;
			end else if (i_triple_detect && o_triple_error_count != ECL_COUNT_MAX) begin
				o_triple_error_count <= o_triple_error_count + 16'h0001;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_first_error_address <= ECL_TRAP_RESET;
			trap_valid_reg <= 1'b0;
		end else if (i_ce) begin
			if (wipe) begin
				o_first_error_address <= ECL_TRAP_RESET;
				trap_valid_reg <= 1'b0;
			end else if (i_triple_detect && (!trap_valid_reg || clear_pulse)) begin
				o_first_error_address <= trap_addr;
				trap_valid_reg <= 1'b1;
			end else if (clear_pulse) begin
				o_first_error_address <= ECL_TRAP_RESET;
				trap_valid_reg <= 1'b0;
			end
		end
	end

	// Counter and trap are exposed read-only; no write path exists.
	assign o_error_status = ECL_BYTE_ZERO | (8'(flag_reg) << ECL_STATUS_TRIPLE_BIT);

	// ****************************************************************
	// Checksum engine
	// ****************************************************************
	logic crc_busy;

	ecl_crc32c u_crc (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_ce(i_ce),
		.i_start(start_pulse),
		.i_pause(pause_pulse),
		.i_continue(cont_pulse),
		.i_word_valid(i_crc_word_valid),
		.i_word(i_crc_word),
		.i_word_last(i_crc_word_last),
		.o_word_ready(o_crc_word_ready),
		.o_crc(o_crc_value),
		.o_busy(crc_busy),
		.o_paused(o_crc_paused)
	);

	assign o_status_one = ECL_BYTE_ZERO | (8'(crc_busy) << ECL_WIP_BIT);

endmodule : ecl_error_log

// [tb/ecl_error_log_properties.sv]
`timescale 1ns/10ps
module ecl_error_log_properties (
	// Clock, reset and enable
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_ce,
	// Array read path events
	input wire logic i_triple_detect,
	input wire logic [23:0] i_detect_addr,
	input wire logic i_reset_event,
	input wire logic i_deep_sleep,
	// Observed outputs
	input wire logic o_unit_query,
	input wire logic o_crc_word_ready,
	input wire logic [7:0] o_error_status,
	input wire logic [15:0] o_triple_error_count,
	input wire logic [31:0] o_first_error_address,
	input wire logic [7:0] o_status_one,
	input wire logic o_crc_paused
);
	logic [31:0] trap_exp_reg;
	logic hit;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	assign hit = i_triple_detect && i_ce && !i_deep_sleep && !i_reset_event;

	// Unit address as the trap should hold it, taken one edge before the check.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			trap_exp_reg <= 32'h0000_0000;
		end else begin
			trap_exp_reg <= {8'h00, i_detect_addr[23:3], 3'b000};
		end
	end

	property p_flag_set;
		hit |=> o_error_status == 8'h10;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set");
	property p_count_inc;
		hit && o_triple_error_count != 16'hFFFF |=>
			o_triple_error_count == $past(o_triple_error_count) + 16'h0001
			|| o_triple_error_count == 16'h0001;
	endproperty
	a_count_inc: assert property (p_count_inc) else $error("count not advanced");
	property p_count_sat;
		hit && o_triple_error_count == 16'hFFFF |=> o_triple_error_count inside {16'hFFFF, 16'h0001};
	endproperty
	a_count_sat: assert property (p_count_sat) else $error("count wrapped");
	property p_sleep_clear;
		i_deep_sleep && i_ce |=> o_triple_error_count == 16'h0000
			&& o_first_error_address == 32'h0000_0000 && o_error_status == 8'h00;
	endproperty
	a_sleep_clear: assert property (p_sleep_clear) else $error("sleep left state");
	property p_count_hold;
		!i_triple_detect |=> $stable(o_triple_error_count) || o_triple_error_count == 16'h0000;
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("count moved alone");
	property p_trap_capture;
		hit && !o_error_status[4] ##1 1'b1 |-> o_first_error_address == trap_exp_reg;
	endproperty
	a_trap_capture: assert property (p_trap_capture) else $error("trap not captured");
	property p_trap_keep;
		o_error_status[4] && !i_deep_sleep && !i_reset_event && !i_triple_detect |=>
			$stable(o_first_error_address) || o_first_error_address == 32'h0000_0000;
	endproperty
	a_trap_keep: assert property (p_trap_keep) else $error("trap overwritten");
	property p_wipe;
		i_reset_event && i_ce |=> o_triple_error_count == 16'h0000
			&& o_first_error_address == 32'h0000_0000 && !o_error_status[4];
	endproperty
	a_wipe: assert property (p_wipe) else $error("reset event left state");
	property p_fixed_zero;
		o_error_status[7:5] == 3'h0 && o_error_status[3:0] == 4'h0
			&& o_first_error_address[2:0] == 3'h0;
	endproperty
	a_fixed_zero: assert property (p_fixed_zero) else $error("reserved bit set");
	property p_query_pulse;
		o_unit_query |=> !o_unit_query;
	endproperty
	a_query_pulse: assert property (p_query_pulse) else $error("query not a pulse");
	property p_wip;
		o_status_one == {7'h00, o_crc_word_ready} && !(o_crc_paused && o_crc_word_ready);
	endproperty
	a_wip: assert property (p_wip) else $error("progress bit wrong");
endmodule : ecl_error_log_properties

bind ecl_error_log ecl_error_log_properties ecl_error_log_properties_i (
	.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_triple_detect(i_triple_detect),
	.i_detect_addr(i_detect_addr), .i_reset_event(i_reset_event), .i_deep_sleep(i_deep_sleep),
	.o_unit_query(o_unit_query), .o_crc_word_ready(o_crc_word_ready),
	.o_error_status(o_error_status), .o_triple_error_count(o_triple_error_count),
	.o_first_error_address(o_first_error_address), .o_status_one(o_status_one),
	.o_crc_paused(o_crc_paused)
);

// [tb/ecl_host.sv]
`timescale 1ns/10ps
module ecl_host (
	// Serial link
	output logic o_sck,
	output logic o_cs_n,
	output logic [3:0] o_io,
	input wire logic [3:0] i_io
);
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_io = 4'h5;
	end

	// Lines the host does not drive toggle, so a stale value is never read as valid.
	task automatic xfer(input logic [31:0] w, input int bits, input int dum, input int step,
			input bit rd, output logic [7:0] rx);
		int i;
		int b;
		rx = 8'h00;
		#7;
		repeat (2) begin
			#16 o_sck = 1'b1;
			#16 o_sck = 1'b0;
		end
		o_cs_n = 1'b0;
		for (i = 0; i < bits; i += step) begin
			for (b = 0; b < 4; b++) o_io[b] = (b < step) ? w[31-i-(step-1-b)] : ~o_io[b];
			#16 o_sck = 1'b1;
			#16 o_sck = 1'b0;
		end
		for (i = 0; rd && i < dum; i++) begin
			o_io = ~o_io;
			#16 o_sck = 1'b1;
			#16 o_sck = 1'b0;
		end
		for (i = 0; rd && i < 8; i += step) begin
			o_io = ~o_io;
			// Sample mid low phase, well after the device has launched the group.
			#8;
			for (b = step - 1; b >= 0; b--) rx = {rx[6:0], i_io[(step == 1) ? 1 : b]};
			#8 o_sck = 1'b1;
			#16 o_sck = 1'b0;
		end
		#16 o_cs_n = 1'b1;
		#32;
	endtask : xfer
endmodule : ecl_host

// [tb/ecl_error_log_tb.sv]
`timescale 1ns/10ps
module ecl_error_log_tb
	import ecl_pkg::*;
;
	logic clk, arst_n, ce, sck, cs_n, det, rst_ev, sleep, ans, triple, wvalid, wlast, uq;
	logic wready, paused;
	logic [1:0] mode;
	logic [3:0] lat, sio, hio, oio, oe_n;
	logic [23:0] daddr;
	logic [31:0] word, trap, crcv, exp_crc;
	logic [20:0] uidx, qidx, bad_idx;
	logic [15:0] cnt;
	logic [7:0] est, sr1, rx;
	int n_mismatch, compares;

	assign sio = (oe_n & hio) | (~oe_n & oio);

	ecl_host ecl_host_i (.o_sck(sck), .o_cs_n(cs_n), .o_io(hio), .i_io(sio));

	ecl_error_log ecl_error_log_i (
		.i_clk(clk), .i_arst_n(arst_n), .i_ce(ce), .i_sck(sck), .i_cs_n(cs_n), .i_io(sio),
		.o_io(oio), .o_io_oe_n(oe_n), .i_line_mode(mode), .i_latency_code(lat),
		.i_triple_detect(det), .i_detect_addr(daddr), .i_reset_event(rst_ev),
		.i_deep_sleep(sleep), .o_unit_query(uq), .o_unit_query_index(uidx),
		.i_unit_answer(ans), .i_unit_triple(triple), .i_crc_word_valid(wvalid),
		.i_crc_word(word), .i_crc_word_last(wlast), .o_crc_word_ready(wready),
		.o_error_status(est), .o_triple_error_count(cnt), .o_first_error_address(trap),
		.o_status_one(sr1), .o_crc_value(crcv), .o_crc_paused(paused)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Array stand-in: answers every unit lookup in the same cycle, so the
	// answer crosses back within the longest latency codes.
	assign ans = uq;
	assign triple = uq && (uidx === bad_idx);
	always @(posedge clk) begin
		if (uq) qidx <= uidx;
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task finish_test;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : finish_test

	function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] w);
		logic [31:0] d;
		d = {w[7:0], w[15:8], w[23:16], w[31:24]};
		for (int i = 31; i >= 0; i--) c = (c << 1) ^ ((c[31] ^ d[i]) ? ECL_CRC_POLY : 32'h0);
		return c;
	endfunction : crc_word

	task regs(input logic [15:0] c, input logic [31:0] t, input logic [7:0] s);
		check(32'(cnt), 32'(c));
		check(trap, t);
		check(32'(est), 32'(s));
	endtask : regs

	task detect(input logic [23:0] a);
		@(posedge clk);
		det <= 1'b1;
		daddr <= a;
		@(posedge clk);
		det <= 1'b0;
		@(posedge clk);
		#1;
	endtask : detect

	task frame(input logic [7:0] op, input logic [23:0] a, input int bits, input int step,
			input bit rd, input logic [1:0] m, input logic [3:0] l);
		@(posedge clk);
		mode <= m;
		lat <= l;
		@(posedge clk);
		ecl_host_i.xfer({op, a}, bits, int'(l), step, rd, rx);
		repeat (6) @(posedge clk);
		#1;
	endtask : frame

	task query(input logic [23:0] a, input logic [1:0] m, input int step, input logic [3:0] l,
			input logic [7:0] exp);
		frame(ECL_OP_UNIT_QUERY, a, 32, step, 1'b1, m, l);
		check(32'(rx), 32'(exp));
		check(32'(qidx), 32'(a[23:3]));
	endtask : query

	task cmd(input logic [7:0] op);
		frame(op, 24'h00_0000, 8, 1, 1'b0, ECL_LINES_SINGLE, 4'h0);
	endtask : cmd

	task feed(input logic [31:0] w, input logic l);
		@(posedge clk);
		wvalid <= 1'b1;
		word <= w;
		wlast <= l;
		@(posedge clk);
		wvalid <= 1'b0;
		wlast <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask : feed

	initial begin
		{arst_n, det, rst_ev, sleep, wvalid, wlast, mode, lat, daddr, word} = '0;
		ce = 1'b1;
		bad_idx = 21'h00_2469;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		#1;
		regs(16'h0000, 32'h0000_0000, 8'h00);
		check(32'(oe_n), 32'hF);
		detect(24'h01_234D);
		regs(16'h0001, 32'h0001_2348, 8'h10);
		detect(24'h00_0100);
		regs(16'h0002, 32'h0001_2348, 8'h10);
		query(24'h01_234F, ECL_LINES_SINGLE, 1, 4'hE, 8'h08);
		query(24'h00_0100, ECL_LINES_DUAL, 2, 4'hF, 8'h00);
		query(24'h01_2348, ECL_LINES_QUAD, 4, 4'hF, 8'h08);
		cmd(ECL_OP_CLEAR_LOG);
		regs(16'h0000, 32'h0000_0000, 8'h00);
		detect(24'h00_0040);
		@(posedge clk);
		rst_ev <= 1'b1;
		@(posedge clk);
		rst_ev <= 1'b0;
		#1;
		regs(16'h0000, 32'h0000_0000, 8'h00);
		@(posedge clk);
		ce <= 1'b0;
		detect(24'h00_0040);
		regs(16'h0000, 32'h0000_0000, 8'h00);
		@(posedge clk);
		ce <= 1'b1;
		detect(24'h00_0040);
		@(posedge clk);
		sleep <= 1'b1;
		@(posedge clk);
		sleep <= 1'b0;
		#1;
		regs(16'h0000, 32'h0000_0000, 8'h00);
		@(posedge clk);
		det <= 1'b1;
		daddr <= 24'h00_000C;
		repeat (65536) @(posedge clk);
		det <= 1'b0;
		@(posedge clk);
		#1;
		regs(16'hFFFF, 32'h0000_0008, 8'h10);
		cmd(ECL_OP_CRC_START);
		check(32'({wready, sr1}), 32'h101);
		feed(32'h1234_5678, 1'b0);
		cmd(ECL_OP_CRC_PAUSE);
		check(32'({paused, sr1}), 32'h100);
		feed(32'hDEAD_BEEF, 1'b1);
		cmd(ECL_OP_CRC_CONTINUE);
		check(32'({paused, sr1}), 32'h001);
		feed(32'h0BAD_F00D, 1'b1);
		exp_crc = crc_word(crc_word(ECL_CRC_INIT, 32'h1234_5678), 32'h0BAD_F00D);
		check(crcv, exp_crc);
		check(32'(sr1), 32'h0);
		finish_test;
	end

	initial begin
		#10_000_000;
		n_mismatch++;
		finish_test;
	end
endmodule : ecl_error_log_tb
